/* inc/framer_pkg.sv */
// Purpose: shared constants for the uplink slot framer
// Assumes: one control channel at fixed spreading factor 256
// Notes: pilot sync words hold the four frame-sync bits per slot
package framer_pkg;
    localparam int SLOT_CHIPS = 2560;
    localparam int FRAME_SLOTS = 15;
    localparam int FRAME_MS = 10;
    localparam int SUPER_MS = 720;
    localparam int SUPER_FRAMES = SUPER_MS / FRAME_MS;
    localparam int CTRL_SF = 256;
    localparam int CTRL_SLOT_BITS = SLOT_CHIPS / CTRL_SF;
    localparam int MAX_K = 6;
    localparam int DATA_BITS_BASE = 10;
    localparam int N_FORMATS = 6;
    localparam int FORMAT_INDICATOR_FIELD_BITS = 30;
    localparam int FORMAT_INDICATOR_FIELD_PER_SLOT = 2;
    localparam logic [11:0] LAST_CHIP = 12'(SLOT_CHIPS - 1);
    localparam logic [3:0] LAST_SLOT = 4'(FRAME_SLOTS - 1);
    localparam logic [6:0] SUPER_TAIL = 7'(SUPER_FRAMES - 1);
    localparam logic [7:0] SYM_MASK_MAX = 8'(CTRL_SF - 1);
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FORMAT_INDICATOR_FIELD = 8'h04;
    localparam logic [7:0] REG_SFN = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam int CTRL_W = 15;
    localparam int CTRL_EN = 0;
    localparam int CTRL_FMT = 1;
    localparam int CTRL_K = 4;
    localparam int CTRL_DATA_ON = 7;
    localparam int CTRL_SITE_SELECTION_SIGNALLING = 8;
    localparam int CTRL_DIV = 9;
    localparam int CTRL_TPC = 10;
    localparam int CTRL_S = 11;
    localparam int CTRL_D = 13;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 15'h0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [3:0] STRB_FULL = 4'hf;
    typedef struct packed {
        logic [3:0] pilot;
        logic [1:0] power_command_field;
        logic [1:0] format_indicator_field;
        logic [1:0] feedback_field;
    } slot_layout_type;
    localparam slot_layout_type LAYOUTS [N_FORMATS] = '{
        '{4'h6, 2'h2, 2'h2, 2'h0}, '{4'h8, 2'h2, 2'h0, 2'h0},
        '{4'h5, 2'h2, 2'h2, 2'h1}, '{4'h7, 2'h2, 2'h0, 2'h1},
        '{4'h6, 2'h2, 2'h0, 2'h2}, '{4'h5, 2'h1, 2'h2, 2'h2}};
    localparam logic [3:0] SYNC_WORDS [FRAME_SLOTS] = '{
        4'he, 4'h2, 4'h5, 4'h0, 4'h9, 4'he, 4'hc, 4'h8,
        4'h6, 4'hf, 4'h5, 4'hb, 4'h8, 4'h3, 4'h3};
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } run_state_type;
endpackage

/* inc/slot_fields_if.sv */
// Purpose: carries slot settings to the control slot builder
// Assumes: fmt below the layout count, slot below 15
// Notes: word is sent most significant bit first
`timescale 1ns/1ns
interface slot_fields_if;
    logic [3:0] slot;
    logic [2:0] fmt;
    logic tpc_cmd;
    logic [1:0] format_indicator_field_pair;
    logic [1:0] s_bits;
    logic [1:0] d_bits;
    logic site_selection_signalling_on;
    logic div_on;
    logic [9:0] word;
    modport builder(input slot, fmt, tpc_cmd, format_indicator_field_pair, s_bits, d_bits,
        site_selection_signalling_on, div_on, output word);
    modport user(output slot, fmt, tpc_cmd, format_indicator_field_pair, s_bits, d_bits,
        site_selection_signalling_on, div_on, input word);
endinterface

/* rtl/ctrl_slot_builder.sv */
// Purpose: assembles one 10-bit control slot word
// Assumes: inputs are stable settings of the slot
// Notes: order is pilot, format indicator, feedback, power command
`timescale 1ns/1ns
module ctrl_slot_builder
    import framer_pkg::*;
(
    slot_fields_if.builder bif
);
    slot_layout_type lay;
    logic [3:0] sy;
    logic [7:0] pilot;
    logic [1:0] fb;
    logic [1:0] fb_mask;
    logic [1:0] tpc2;
    logic [1:0] tf;
    logic [3:0] pos_fb;
    logic [3:0] pos_tpc;

    always_comb
    begin
        lay = LAYOUTS[bif.fmt];
        sy = SYNC_WORDS[bif.slot];
        // non-sync pilot bits are ones
        unique case (lay.pilot)
            4'h5: pilot = {sy[3], sy[2], 1'b1, sy[1], sy[0], 3'h0};
            4'h6: pilot = {1'b1, sy[3], sy[2], 1'b1, sy[1], sy[0], 2'h0};
            4'h7: pilot = {1'b1, sy[3], sy[2], 1'b1, sy[1], sy[0], 2'h2};
            default: pilot = {1'b1, sy[3], 1'b1, sy[2], 1'b1, sy[1],
                1'b1, sy[0]};
        endcase
        if (bif.site_selection_signalling_on && bif.div_on)
            fb = {bif.s_bits[1], bif.d_bits[1]};
        else if (bif.div_on)
            fb = bif.d_bits;
        else
            fb = bif.s_bits;
        unique case (lay.feedback_field)
            2'h0: fb_mask = 2'h0;
            2'h1: fb_mask = 2'h2;
            default: fb_mask = 2'h3;
        endcase
        // one command bit or a doubled pair
        tpc2 = (lay.power_command_field == 2'h1) ? {bif.tpc_cmd, 1'b0}
            : {bif.tpc_cmd, bif.tpc_cmd};
        tf = (lay.format_indicator_field == 2'h2) ? bif.format_indicator_field_pair : 2'h0;
        pos_fb = lay.pilot + 4'(lay.format_indicator_field);
        pos_tpc = pos_fb + 4'(lay.feedback_field);
        bif.word = {pilot, 2'h0} | ({tf, 8'h00} >> lay.pilot)
            | ({fb & fb_mask, 8'h00} >> pos_fb)
            | ({tpc2, 8'h00} >> pos_tpc);
    end
endmodule

/* rtl/uplink_dedicated_slot_framer.sv */
// Purpose: uplink dedicated channel slot, frame and superframe framer
// Assumes: chip_tick_i is a one-cycle chip strobe from clk_i logic
// Notes: data channel on the I branch, control channel on Q
`timescale 1ns/1ns
module uplink_dedicated_slot_framer
    import framer_pkg::*;
#(
    parameter int SFN_W = 12,
    parameter int ADDR_W = 8
)
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    input wire logic chip_tick_i,
    input wire logic data_bit_i,
    output logic data_take_o,
    output logic chip_valid_o,
    output logic i_branch_o,
    output logic q_branch_o,
    output logic slot_start_o,
    output logic frame_start_o,
    output logic superframe_head_o,
    output logic superframe_tail_o,
    output logic [3:0] slot_index_o,
    output logic [SFN_W-1:0] system_frame_number_o
);
    localparam logic [SFN_W-1:0] SUPER_N = SFN_W'(SUPER_FRAMES);
    localparam int TW = FORMAT_INDICATOR_FIELD_BITS;

    if (SFN_W < 7 || SFN_W > 16 || ADDR_W < 4 || ADDR_W > 8)
    begin : g_chk
        $error("framer parameters out of range");
    end

    logic rst_meta_q, rst_n_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [TW-1:0] format_indicator_field_q, format_indicator_field_l_q;
    logic [SFN_W-1:0] sfn_q;
    logic [2:0] k_l_q;
    logic data_on_l_q;
    run_state_type state_q;
    logic [11:0] chip_q;
    logic [3:0] slot_q;
    logic [9:0] word_q;
    logic pre_q, take_prev_q;
    logic [9:0] sym_cnt_q;
    logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic w_full_q;
    logic [1:0] bresp_q;
    logic arready_q, rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic i_q, q_q, take_q, chip_v_q, slot_st_q, frame_st_q;
    logic head_q, tail_q;

    logic aw_hold_d, w_hold_d, bvalid_d, do_write;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic wr_ok, sfn_wr;
    logic run, adv, slot_begin, frame_begin, chip_last, slot_last;
    logic sym_start, data_on_cur;
    logic [2:0] k_cur;
    logic [TW-1:0] format_indicator_field_src, format_indicator_field_sh;
    logic [9:0] word_cur;
    logic [6:0] sfn_mod;
    logic [3:0] bit_idx;

    slot_fields_if bif();
    ctrl_slot_builder u_builder (.bif(bif));

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // write channel: address and data in either order
    always_comb
    begin
        aw_hold_d = aw_hold_q | (awvalid_i & awready_q);
        w_hold_d = w_hold_q | (wvalid_i & wready_q);
        do_write = aw_hold_d & w_hold_d & ~bvalid_q;
        bvalid_d = bvalid_q & ~bready_i;
        wr_addr = aw_hold_q ? awaddr_q : awaddr_i;
        wr_data = w_hold_q ? wdata_q : wdata_i;
        if (do_write)
        begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
        end
        // a held data beat keeps its own strobe verdict
        wr_ok = w_hold_q ? w_full_q : wstrb_i == STRB_FULL;
        sfn_wr = do_write && wr_addr == ADDR_W'(REG_SFN);
    end

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            w_full_q <= 1'b0;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awready_q <= ~aw_hold_d & ~bvalid_d;
            wready_q <= ~w_hold_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
            if (awvalid_i && awready_q)
                awaddr_q <= awaddr_i;
            if (wvalid_i && wready_q)
            begin
                wdata_q <= wdata_i;
                w_full_q <= wstrb_i == STRB_FULL;
            end
            if (do_write)
            begin
                bresp_q <= RESP_OKAY;
                unique case (wr_addr)
                    ADDR_W'(REG_CTRL):
                        if (!wr_ok
                            || wr_data[CTRL_FMT+:3] >= 3'(N_FORMATS)
                            || wr_data[CTRL_K+:3] > 3'(MAX_K))
                            bresp_q <= RESP_SLVERR;
                    ADDR_W'(REG_FORMAT_INDICATOR_FIELD), ADDR_W'(REG_SFN), ADDR_W'(REG_STATUS):
                        if (!wr_ok)
                            bresp_q <= RESP_SLVERR;
                    default: bresp_q <= RESP_SLVERR;
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ctrl_q <= CTRL_RESET;
            format_indicator_field_q <= '0;
        end
        else if (do_write && wr_ok)
        begin
            if (wr_addr == ADDR_W'(REG_CTRL)
                && wr_data[CTRL_FMT+:3] < 3'(N_FORMATS)
                && wr_data[CTRL_K+:3] <= 3'(MAX_K))
                ctrl_q <= wr_data[CTRL_W-1:0];
            if (wr_addr == ADDR_W'(REG_FORMAT_INDICATOR_FIELD))
                format_indicator_field_q <= wr_data[TW-1:0];
        end
    end

    // read channel, one cycle answer
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else if (rvalid_q)
        begin
            if (rready_i)
            begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
        else if (arvalid_i && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            unique case (araddr_i)
                ADDR_W'(REG_CTRL): rdata_q <= 32'(ctrl_q);
                ADDR_W'(REG_FORMAT_INDICATOR_FIELD): rdata_q <= 32'(format_indicator_field_q);
                ADDR_W'(REG_SFN): rdata_q <= 32'(sfn_q);
                ADDR_W'(REG_STATUS):
                    rdata_q <= 32'({state_q, sfn_mod, slot_q});
                default:
                begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end
        else
            arready_q <= 1'b1;
    end

    // slot timing
    always_comb
    begin
        run = state_q == ST_RUN;
        adv = run & chip_tick_i;
        slot_begin = adv && chip_q == '0;
        frame_begin = slot_begin && slot_q == '0;
        chip_last = chip_q == LAST_CHIP;
        slot_last = slot_q == LAST_SLOT;
        sfn_mod = 7'(sfn_q % SUPER_N);
        k_cur = frame_begin ? ctrl_q[CTRL_K+:3] : k_l_q;
        data_on_cur = frame_begin ? ctrl_q[CTRL_DATA_ON] : data_on_l_q;
        // symbol edge every 256 over two to the k chips
        sym_start = adv
            && (chip_q[7:0] & (SYM_MASK_MAX >> k_cur)) == 8'h00;
        format_indicator_field_src = frame_begin ? format_indicator_field_q : format_indicator_field_l_q;
        format_indicator_field_sh = format_indicator_field_src << (FORMAT_INDICATOR_FIELD_PER_SLOT * slot_q);
        word_cur = slot_begin ? bif.word : word_q;
        bit_idx = 4'(CTRL_SLOT_BITS - 1) - chip_q[11:8];
        bif.slot = slot_q;
        bif.fmt = ctrl_q[CTRL_FMT+:3];
        bif.tpc_cmd = ctrl_q[CTRL_TPC];
        bif.format_indicator_field_pair = format_indicator_field_sh[TW-1-:2];
        bif.s_bits = ctrl_q[CTRL_S+:2];
        bif.d_bits = ctrl_q[CTRL_D+:2];
        bif.site_selection_signalling_on = ctrl_q[CTRL_SITE_SELECTION_SIGNALLING];
        bif.div_on = ctrl_q[CTRL_DIV];
    end

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            state_q <= ST_IDLE;
        else
            unique case (state_q)
                ST_IDLE: if (ctrl_q[CTRL_EN]) state_q <= ST_RUN;
                ST_RUN: if (!ctrl_q[CTRL_EN] && chip_q == '0)
                    state_q <= ST_IDLE;
            endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            chip_q <= '0;
            slot_q <= '0;
            sfn_q <= '0;
        end
        else
        begin
            if (adv)
                chip_q <= chip_last ? '0 : chip_q + 12'h001;
            if (adv && chip_last)
                slot_q <= slot_last ? '0 : slot_q + 4'h1;
            if (sfn_wr && wr_ok)
                sfn_q <= wr_data[SFN_W-1:0];
            else if (adv && chip_last && slot_last)
                sfn_q <= sfn_q + SFN_W'(1);
        end
    end

    // per-frame and per-slot settings
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            k_l_q <= '0;
            data_on_l_q <= 1'b0;
            format_indicator_field_l_q <= '0;
            word_q <= '0;
        end
        else
        begin
            if (frame_begin)
            begin
                k_l_q <= ctrl_q[CTRL_K+:3];
                data_on_l_q <= ctrl_q[CTRL_DATA_ON];
                format_indicator_field_l_q <= format_indicator_field_q;
            end
            if (slot_begin)
                word_q <= bif.word;
        end
    end

    // branch outputs and data fetch
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            i_q <= 1'b0;
            q_q <= 1'b0;
            take_q <= 1'b0;
            take_prev_q <= 1'b0;
            pre_q <= 1'b0;
            sym_cnt_q <= '0;
        end
        else
        begin
            take_q <= sym_start & data_on_cur;
            take_prev_q <= take_q;
            if (take_prev_q || !run)
                pre_q <= data_bit_i;
            if (sym_start)
            begin
                i_q <= data_on_cur & pre_q;
                sym_cnt_q <= slot_begin ? 10'h001 : sym_cnt_q + 10'h001;
            end
            if (adv && chip_q[7:0] == 8'h00)
                q_q <= word_cur[bit_idx];
            if (!run)
                i_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            chip_v_q <= 1'b0;
            slot_st_q <= 1'b0;
            frame_st_q <= 1'b0;
            head_q <= 1'b0;
            tail_q <= 1'b0;
        end
        else
        begin
            chip_v_q <= adv;
            slot_st_q <= slot_begin;
            frame_st_q <= frame_begin;
            head_q <= run && sfn_mod == '0;
            tail_q <= run && sfn_mod == SUPER_TAIL;
        end
    end

    assign awready_o = awready_q;
    assign wready_o = wready_q;
    assign bvalid_o = bvalid_q;
    assign bresp_o = bresp_q;
    assign arready_o = arready_q;
    assign rvalid_o = rvalid_q;
    assign rdata_o = rdata_q;
    assign rresp_o = rresp_q;
    assign data_take_o = take_q;
    assign chip_valid_o = chip_v_q;
    assign i_branch_o = i_q;
    assign q_branch_o = q_q;
    assign slot_start_o = slot_st_q;
    assign frame_start_o = frame_st_q;
    assign superframe_head_o = head_q;
    assign superframe_tail_o = tail_q;
    assign slot_index_o = slot_q;
    assign system_frame_number_o = sfn_q;

    sequence s_frame_end;
        adv && chip_last && slot_last;
    endsequence
    sequence s_tail_frame;
        sfn_mod == SUPER_TAIL && !sfn_wr;
    endsequence

    property p_super_wrap;
        @(posedge clk_i) disable iff (!rst_n_q)
        (s_frame_end and s_tail_frame) |=> sfn_mod == 7'h00;
    endproperty
    a_super_wrap: assert property (p_super_wrap)
        else $error("superframe did not restart after its tail frame");

    property p_slot_wrap;
        @(posedge clk_i) disable iff (!rst_n_q)
        (adv && chip_last) |=> chip_q == '0
            && slot_q == ($past(slot_last) ? 4'h0 : $past(slot_q) + 4'h1);
    endproperty
    a_slot_wrap: assert property (p_slot_wrap)
        else $error("slot did not end after 2560 chips");

    property p_data_steady;
        @(posedge clk_i) disable iff (!rst_n_q)
        (run && $changed(i_q)) |-> $past(sym_start);
    endproperty
    a_data_steady: assert property (p_data_steady)
        else $error("data bit changed inside a symbol");

    property p_data_count;
        @(posedge clk_i) disable iff (!rst_n_q)
        (adv && chip_last) |=>
            sym_cnt_q == (10'(DATA_BITS_BASE) << k_l_q);
    endproperty
    a_data_count: assert property (p_data_count)
        else $error("wrong number of data symbols in a slot");

    property p_ctrl_steady;
        @(posedge clk_i) disable iff (!rst_n_q)
        $changed(q_q) |-> $past(adv && chip_q[7:0] == 8'h00);
    endproperty
    a_ctrl_steady: assert property (p_ctrl_steady)
        else $error("control bit changed inside a 256-chip symbol");

    property p_pilot_lead;
        @(posedge clk_i) disable iff (!rst_n_q)
        (slot_begin && LAYOUTS[ctrl_q[CTRL_FMT+:3]].pilot != 4'h5)
            |=> word_q[9] && q_q;
    endproperty
    a_pilot_lead: assert property (p_pilot_lead)
        else $error("leading non-sync pilot bit not one");

    property p_word_hold;
        @(posedge clk_i) disable iff (!rst_n_q)
        $changed(word_q) |-> $past(slot_begin);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("slot content changed between slot boundaries");

    property p_format_indicator_field_hold;
        @(posedge clk_i) disable iff (!rst_n_q)
        $changed(format_indicator_field_l_q) |-> $past(frame_begin);
    endproperty
    a_format_indicator_field_hold: assert property (p_format_indicator_field_hold)
        else $error("format indicator changed inside a frame");

    sequence s_resp_wait;
        bvalid_q && !bready_i;
    endsequence
    property p_bresp_hold;
        @(posedge clk_i) disable iff (!rst_n_q)
        s_resp_wait |=> bvalid_q && $stable(bresp_q);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write response dropped before it was taken");
endmodule

/* verification/chip_sink.sv */
// Purpose: chip strobe and data source, slot chip and take counter
// Assumes: clocked by the framer clock
// Notes: chip strobe stalls at random, data bit changes at random after a take
`timescale 1ns/1ns
module chip_sink
(
    input wire logic clk_i,
    input wire logic slot_start_i,
    input wire logic chip_valid_i,
    input wire logic data_take_i,
    output logic chip_tick_o,
    output logic data_bit_o,
    output int chips_o,
    output int takes_o
);
    logic [7:0] lf_q = 8'h5a;
    initial
    begin
        chip_tick_o = 1'b0;
        data_bit_o = 1'b1;
        chips_o = 0;
        takes_o = 0;
    end
    always @(posedge clk_i)
    begin
        lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
        chip_tick_o <= lf_q[1:0] != 2'b00;
        if (data_take_i)
            data_bit_o <= ~data_bit_o ^ lf_q[6];
        if (chip_valid_i)
            chips_o <= slot_start_i ? 1 : chips_o + 1;
        if (slot_start_i)
            takes_o <= int'(data_take_i);
        else if (data_take_i)
            takes_o <= takes_o + 1;
    end
endmodule

/* verification/test_uplink_dedicated_slot_framer.sv */
// Purpose: self-checking bench for the uplink slot framer
// Assumes: registers reached over the register bus
// Notes: control slot layout changes at random mid-slot
`timescale 1ns/1ns
module test_uplink_dedicated_slot_framer
    import framer_pkg::*;
;
    logic clk_i = 0, rstn_i = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, tick, dbit, bv, rv;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic [3:0] wstrb = 0;
    logic [1:0] rsp;
    logic [9:0] qw = 0;
    logic [14:0] ctrl = 0, sctrl = 0;
    logic [29:0] format_indicator_field;
    int n_errors = 0, checks = 0, nslots = 0, cidx = 0, chips, takes;
    int seed = 32'h2dbb5a27, k0;
    logic aw_r, w_r, b_o, ar_r, r_o, dt, cv, ib, qb, ss, fs, sh, st;
    logic [1:0] br, rr;
    logic [31:0] rdo;
    logic [3:0] si;
    logic [11:0] system_frame_number;
    always #4 clk_i = ~clk_i;
    uplink_dedicated_slot_framer uplink_dedicated_slot_framer_i (.clk_i,
        .rstn_i, .awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(aw_r),
        .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
        .wready_o(w_r), .bresp_o(br), .bvalid_o(b_o), .bready_i(bready),
        .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(ar_r),
        .rdata_o(rdo), .rresp_o(rr), .rvalid_o(r_o), .rready_i(rready),
        .chip_tick_i(tick), .data_bit_i(dbit), .data_take_o(dt),
        .chip_valid_o(cv), .i_branch_o(ib), .q_branch_o(qb),
        .slot_start_o(ss), .frame_start_o(fs), .superframe_head_o(sh),
        .superframe_tail_o(st), .slot_index_o(si),
        .system_frame_number_o(system_frame_number));
    chip_sink chip_sink_i (.clk_i, .slot_start_i(ss), .chip_valid_i(cv),
        .data_take_i(dt), .chip_tick_o(tick), .data_bit_o(dbit),
        .chips_o(chips), .takes_o(takes));
    task automatic complete_run;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string m);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk_i);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1; wvalid <= 1; bready <= 1;
        do
        begin
            @(posedge clk_i);
            if (awvalid && aw_r) awvalid <= 0;
            if (wvalid && w_r) wvalid <= 0;
        end while (b_o !== 1'b1);
        rsp = br;
        bready <= 0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clk_i);
        araddr <= a; arvalid <= 1; rready <= 1;
        do
        begin
            @(posedge clk_i);
            if (arvalid && ar_r) arvalid <= 0;
        end while (r_o !== 1'b1);
        rsp = rr; rd = rdo;
        rready <= 0;
    endtask
    function automatic logic [9:0] exp_word(logic [14:0] c, int s);
        slot_layout_type l;
        logic [3:0] w;
        logic [1:0] f;
        logic [9:0] r;
        l = LAYOUTS[c[3:1]];
        w = SYNC_WORDS[s];
        case (l.pilot)
            4'h5: r = 10'({w[3:2], 1'b1, w[1:0]});
            4'h6: r = 10'({1'b1, w[3:2], 1'b1, w[1:0]});
            4'h7: r = 10'({1'b1, w[3:2], 1'b1, w[1:0], 1'b1});
            default: r = 10'({1'b1, w[3], 1'b1, w[2], 1'b1, w[1], 1'b1, w[0]});
        endcase
        if (l.format_indicator_field != 0) r = {r[7:0], format_indicator_field[29-2*s], format_indicator_field[28-2*s]};
        f = (c[8] & c[9]) ? {c[12], c[14]} : (c[9] ? c[14:13] : c[12:11]);
        if (l.feedback_field == 2) r = {r[7:0], f};
        if (l.feedback_field == 1) r = {r[8:0], f[1]};
        r = (l.power_command_field == 2) ? {r[7:0], {2{c[10]}}} : {r[8:0], c[10]};
        return r;
    endfunction
    always @(posedge clk_i)
        if (cv === 1'b1)
        begin
            if (ss === 1'b1)
            begin
                if (nslots > 0)
                begin
                    chk(chips, 2560, "chips per slot");
                    chk(takes, 10 << k0, "data bits per slot");
                    chk(32'(qw), 32'(exp_word(sctrl, (nslots-1)%15)), "ctrl");
                end
                chk(32'(si), nslots % 15, "slot index");
                chk(32'(fs), 32'(nslots % 15 == 0), "frame start");
                if (nslots % 15 != 0)
                begin
                    chk(32'(st), 32'(nslots < 15), "tail");
                    chk(32'(sh), 32'(nslots > 15), "head");
                    chk(32'(system_frame_number), nslots < 15 ? 71 : 72, "frame num");
                end
                nslots++;
                cidx = 0;
                sctrl = ctrl;
            end
            else
                cidx++;
            if (cidx % 256 == 0) qw = {qw[8:0], qb};
            if (dt === 1'b1) chk(32'(ib), 32'(dbit), "data bit");
        end
    initial
    begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end
    initial
    begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1;
        repeat (4) @(posedge clk_i);
        axr(REG_CTRL); chk(rd, 0, "ctrl reset");
        axr(8'h10); chk(32'(rsp), 32'(RESP_SLVERR), "unmapped");
        axw(REG_CTRL, 32'h000d, STRB_FULL); chk(32'(rsp), 32'(RESP_SLVERR), "fmt");
        axw(REG_CTRL, 32'h0001, 4'h3); chk(32'(rsp), 32'(RESP_SLVERR), "strb");
        axr(REG_CTRL); chk(rd, 0, "ctrl kept");
        axw(REG_SFN, 71, STRB_FULL);
        format_indicator_field = 30'($random(seed));
        axw(REG_FORMAT_INDICATOR_FIELD, 32'(format_indicator_field), STRB_FULL); chk(32'(rsp), 0, "format_indicator_field");
        k0 = $unsigned($random(seed)) % 7;
        while (nslots < 17)
        begin
            ctrl = 15'($random(seed));
            ctrl[3:1] = 3'($unsigned($random(seed)) % 6);
            ctrl[6:0] = {3'(k0), ctrl[3:1], 1'b1};
            ctrl[7] = 1'b1;
            axw(REG_CTRL, 32'(ctrl), STRB_FULL);
            @(posedge ss);
            repeat (500) @(posedge clk_i);
        end
        axr(REG_STATUS);
        chk(32'(rd[11:4]), 32'h80, "status");
        complete_run();
    end
endmodule
